// ===== hdl/cpm_bit_tick.sv
// cpm_bit_tick.sv - one pulse per nominal bit time
// assumes: bit_len is cycles per bit minus one, held steady while run
module cpm_bit_tick
	import cpm_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        run,
	input  wire logic [15:0] bit_len,
	output logic             tick
);
	typedef struct packed {
		logic [15:0] cnt;   // cycles left in bit
		logic        tick;  // registered pulse
	} cpm_tick_type;

	cpm_tick_type cur;   // state
	cpm_tick_type next_cur; // next state

	// ==========================================================
	// reload counter; held at zero while stopped
	always_comb begin
		next_cur = cur;
		next_cur.tick = 1'b0;
		if (!run) begin
			next_cur.cnt = 16'h0000;
		end else if (cur.cnt == 16'h0000) begin
			next_cur.cnt = bit_len;
			next_cur.tick = 1'b1;
		end else begin
			next_cur.cnt = cur.cnt - 16'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign tick = cur.tick;
endmodule : cpm_bit_tick

// ===== hdl/cpm_core.sv
// cpm_core.sv - power, enable, sync, interrupt mask and rx mailbox
// assumes: APB master on pclk; frame engine drives the event pulses
// and mailbox words synchronous to pclk; can_rx already synchronous
`include "cpm_defs.svh"

// How it works
// R1 - sleep waits until no transmit is pending
// R2 - sleep entry sets flag, masked interrupt
// R3 - sleep and wakeup flags clear each other
// R4 - sleep stops reception and error counters
// R5 - software waits for sleep before clock gating
// R6 - software restores clock, then clears request
// R7 - wake after eleven recessive bits only
// R8 - idle bus allows sending eleven bits later
// R9 - busy bus defers sync to interframe
// R10 - enable resets state, counters, error flags
// R11 - software sets bit timing before enable
// R12 - enable syncs then sets wakeup flag
// R13 - autobaud locks counters, software tunes timing
// R14 - disable/enable writes mask, masked at reset
// R15 - eight system sources plus mailbox source
// R16 - frame start/end captures timer, flags
// R17 - timer and timestamp clear on status read
// R18 - plain mode keeps first message, ready
// R19 - transfer command clears ready flag
// R20 - plain mode drops later messages, lost
// R21 - overwrite mode replaces data, sets lost
// R22 - software checks lost around data reads
// R23 - autobaud listens only, no ack, no send
module cpm_core
	import cpm_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        can_rx,
	input  wire logic        tx_pending,
	input  wire logic        frame_sof,
	input  wire logic        frame_eof,
	input  wire logic        rx_frame_valid,
	input  wire logic [31:0] rx_data_low,
	input  wire logic [31:0] rx_data_high,
	input  wire logic        rx_error,
	input  wire logic        tx_error,
	input  wire logic        rx_ok,
	input  wire logic        tx_ok,
	output logic             rx_enable,
	output logic             ack_enable,
	output logic             tx_permit,
	output logic             irq
);
	// ==========================================================
	// state
	typedef struct packed {
		cpm_state_type  st;       // controller state
		logic [2:0]     mode;     // enable, lpm, autobaud
		logic           en_d;     // enable last cycle
		logic [15:0]    btr;      // cycles per bit - 1
		logic [31:0]    imr;      // interrupt mask, 1 = on
		logic [8:0]     tec;      // transmit error count
		logic [8:0]     rec;      // receive error count
		logic           erra;     // error active
		logic           warn;     // warning level
		logic           errp;     // error passive
		logic           boff;     // bus off
		logic           sleep;    // sleep status
		logic           wake;     // wakeup status
		logic           tovf;     // timer rolled over
		logic           tstp;     // timestamp taken
		logic [15:0]    timer;    // free bit-time timer
		logic [15:0]    tstamp;   // captured timer
		cpm_mbtype_type mb_type;  // mailbox object type
		logic           mb_rdy;   // mailbox ready
		logic           mb_lost;  // message lost
		logic [31:0]    mb_low;   // data low word
		logic [31:0]    mb_high;  // data high word
		logic [31:0]    rdata;    // read data register
		logic           err;      // slave error
	} cpm_core_type;

	cpm_core_type cur;      // state
	cpm_core_type next_cur; // next state

	logic        bit_tick;  // one pulse per bit
	logic        idle_seen; // eleven recessive bits
	logic        setup;     // apb setup phase
	logic        wr;        // apb write access
	logic        rd;        // apb read access
	logic [31:0] sr;        // live status word
	logic        hit;       // address is mapped
	logic        cnt_run;   // error counters may move

	// ==========================================================
	// bit timing and idle detection
	cpm_bit_tick u_tick (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (cur.st != CPM_OFF),
		.bit_len (cur.btr),
		.tick    (bit_tick)
	);

	// R7 eleven recessive bits
	cpm_idle_detect u_idle (
		.pclk      (pclk),
		.presetn   (presetn),
		.enable    (cur.st == CPM_SYNC),
		.tick      (bit_tick),
		.can_rx    (can_rx),
		.idle_seen (idle_seen)
	);

	// ==========================================================
	// bus phases and status word
	assign setup = psel && !penable;
	assign wr    = psel && penable && pwrite;
	assign rd    = psel && penable && !pwrite;

	// R15 system source layout
	always_comb begin
		sr = 32'h00000000;
		sr[`CPM_SR_MB]    = cur.mb_rdy;
		sr[`CPM_SR_ERRA]  = cur.erra;
		sr[`CPM_SR_WARN]  = cur.warn;
		sr[`CPM_SR_ERRP]  = cur.errp;
		sr[`CPM_SR_BOFF]  = cur.boff;
		sr[`CPM_SR_SLEEP] = cur.sleep;
		sr[`CPM_SR_WAKE]  = cur.wake;
		sr[`CPM_SR_TOVF]  = cur.tovf;
		sr[`CPM_SR_TSTP]  = cur.tstp;
	end

	// address decode, used only for the slave error
	always_comb begin
		case (paddr)
			`CPM_MODE_OFS, `CPM_IER_OFS, `CPM_IDR_OFS,
			`CPM_IMR_OFS, `CPM_SR_OFS, `CPM_BTR_OFS,
			`CPM_ECR_OFS, `CPM_TSTAMP_OFS, `CPM_MB_MODE_OFS,
			`CPM_MB_STAT_OFS, `CPM_MB_LOW_OFS,
			`CPM_MB_HIGH_OFS, `CPM_MB_CTRL_OFS: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	// R4 counters stop in sleep
	// R13 counters locked in autobaud
	assign cnt_run = (cur.st == CPM_ACTIVE) && !cur.mode[`CPM_MODE_ABD];

	// ==========================================================
	// next state: order of assignments sets priority, so
	// hardware sets placed after software clears win
	always_comb begin
		next_cur = cur;
		next_cur.en_d = cur.mode[`CPM_MODE_EN];

		// read data is captured in setup so access has no wait
		if (setup) begin
			next_cur.err = !hit;
			case (paddr)
				`CPM_MODE_OFS:    next_cur.rdata = {29'h0, cur.mode};
				`CPM_IMR_OFS:     next_cur.rdata = cur.imr;
				`CPM_SR_OFS:      next_cur.rdata = sr;
				`CPM_BTR_OFS:     next_cur.rdata = {16'h0, cur.btr};
				`CPM_ECR_OFS:     next_cur.rdata = {7'h0, cur.tec,
				                                    7'h0, cur.rec};
				`CPM_TSTAMP_OFS:  next_cur.rdata = {16'h0, cur.tstamp};
				`CPM_MB_MODE_OFS: next_cur.rdata = {5'h0, cur.mb_type,
				                                    24'h0};
				`CPM_MB_STAT_OFS: next_cur.rdata = {7'h0, cur.mb_lost,
				                                    cur.mb_rdy, 23'h0};
				`CPM_MB_LOW_OFS:  next_cur.rdata = cur.mb_low;
				`CPM_MB_HIGH_OFS: next_cur.rdata = cur.mb_high;
				default:          next_cur.rdata = 32'h00000000;
			endcase
		end

		// register writes; write-only registers read as zero
		if (wr) begin
			case (paddr)
				`CPM_MODE_OFS: next_cur.mode = pwdata[2:0];
				// R14 enable and disable
				`CPM_IER_OFS: next_cur.imr = cur.imr
				                   | (pwdata & `CPM_IRQ_VALID);
				`CPM_IDR_OFS: next_cur.imr = cur.imr & ~pwdata;
				`CPM_BTR_OFS: next_cur.btr = pwdata[15:0];
				`CPM_MB_MODE_OFS: begin
					next_cur.mb_type = cpm_mbtype_type'(
					    pwdata[`CPM_MB_TYPE_LSB +: 3]);
					// arming the mailbox starts it empty
					next_cur.mb_rdy = 1'b0;
				end
				`CPM_MB_CTRL_OFS: begin
					// R19 transfer command clears
					if (pwdata[`CPM_MB_TCMD]) begin
						next_cur.mb_rdy = 1'b0;
					end
				end
				default: ;
			endcase
		end

		// read side effects
		if (rd && paddr == `CPM_SR_OFS) begin
			// R17 cleared on status read
			next_cur.tovf = 1'b0;
			next_cur.tstp = 1'b0;
		end
		if (rd && paddr == `CPM_MB_STAT_OFS) begin
			next_cur.mb_lost = 1'b0;
		end

		// free timer and event flags run while enabled
		if (cur.st != CPM_OFF && bit_tick) begin
			next_cur.timer = cur.timer + 16'h0001;
			if (cur.timer == 16'hFFFF) begin
				next_cur.tovf = 1'b1;
			end
		end
		// R16 capture timer on frame edge
		if (cur.st == CPM_ACTIVE && (frame_sof || frame_eof)) begin
			next_cur.tstamp = cur.timer;
			next_cur.tstp = 1'b1;
		end

		// R10 error counters move only when allowed
		if (cnt_run) begin
			if (tx_error) begin
				next_cur.tec = (cur.tec > `CPM_CNT_MAX - `CPM_TEC_STEP)
				             ? `CPM_CNT_MAX : cur.tec + `CPM_TEC_STEP;
			end else if (tx_ok && cur.tec != 9'h000) begin
				next_cur.tec = cur.tec - 9'h001;
			end
			if (rx_error && cur.rec != `CPM_CNT_MAX) begin
				next_cur.rec = cur.rec + 9'h001;
			end else if (rx_ok && cur.rec != 9'h000) begin
				next_cur.rec = cur.rec - 9'h001;
			end
		end

		// error flags follow the counters; autobaud still flags
		if (cur.st != CPM_OFF) begin
			next_cur.boff = cur.tec > `CPM_BOFF_LIM;
			next_cur.errp = !next_cur.boff
			    && (cur.tec > `CPM_PASS_LIM || cur.rec > `CPM_PASS_LIM);
			next_cur.erra = !next_cur.boff && !next_cur.errp;
			next_cur.warn = next_cur.erra
			    && (cur.tec > `CPM_WARN_LIM || cur.rec > `CPM_WARN_LIM);
		end

		// R18 plain mode keeps first
		// R20 plain mode drops, lost
		// R21 overwrite replaces, lost
		if (rx_frame_valid && cur.st == CPM_ACTIVE) begin
			case (cur.mb_type)
				CPM_MB_RX: begin
					if (next_cur.mb_rdy) begin
						next_cur.mb_lost = 1'b1;
					end else begin
						next_cur.mb_low  = rx_data_low;
						next_cur.mb_high = rx_data_high;
						next_cur.mb_rdy  = 1'b1;
					end
				end
				CPM_MB_RXOW: begin
					if (next_cur.mb_rdy) begin
						next_cur.mb_lost = 1'b1;
					end
					next_cur.mb_low  = rx_data_low;
					next_cur.mb_high = rx_data_high;
					next_cur.mb_rdy  = 1'b1;
				end
				default: ;
			endcase
		end

		// controller state machine
		case (cur.st)
			CPM_OFF: begin
				// R10 enable rising resets counters, error flags, timer
				if (cur.mode[`CPM_MODE_EN] && !cur.en_d) begin
					next_cur.st    = CPM_SYNC;
					next_cur.tec   = 9'h000;
					next_cur.rec   = 9'h000;
					next_cur.erra  = 1'b0;
					next_cur.warn  = 1'b0;
					next_cur.errp  = 1'b0;
					next_cur.boff  = 1'b0;
					next_cur.timer = 16'h0000;
				end
			end
			CPM_SYNC: begin
				if (!cur.mode[`CPM_MODE_EN]) begin
					next_cur.st = CPM_OFF;
				end else if (cur.mode[`CPM_MODE_LPM] && !tx_pending) begin
					// sleep request before sync completes
					next_cur.st    = CPM_SLEEP;
					next_cur.sleep = 1'b1;
					next_cur.wake  = 1'b0;
				end else if (idle_seen) begin
					// R12 synced sets wakeup
					// R3 wakeup clears sleep
					next_cur.st    = CPM_ACTIVE;
					next_cur.wake  = 1'b1;
					next_cur.sleep = 1'b0;
				end
			end
			CPM_ACTIVE: begin
				if (!cur.mode[`CPM_MODE_EN]) begin
					next_cur.st = CPM_OFF;
				// R1 drain pending sends first
				end else if (cur.mode[`CPM_MODE_LPM] && !tx_pending) begin
					// R2 sleep flag on entry
					// R3 sleep clears wakeup
					next_cur.st    = CPM_SLEEP;
					next_cur.sleep = 1'b1;
					next_cur.wake  = 1'b0;
				end
			end
			CPM_SLEEP: begin
				if (!cur.mode[`CPM_MODE_EN]) begin
					next_cur.st = CPM_OFF;
				end else if (!cur.mode[`CPM_MODE_LPM]) begin
					// R9 resync before any frame
					next_cur.st = CPM_SYNC;
				end
			end
			default: next_cur.st = CPM_OFF;
		endcase
	end

	// ==========================================================
	// state register; everything starts disabled and masked
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur         <= '0;
			cur.btr     <= `CPM_BTR_RST;
			cur.st      <= CPM_OFF;
			cur.mb_type <= CPM_MB_OFF;
		end else begin
			cur <= next_cur;
		end
	end

	// ==========================================================
	// outputs
	assign pready  = 1'b1;
	assign prdata  = cur.rdata;
	assign pslverr = cur.err && psel && penable;

	// R4 no reception while asleep
	assign rx_enable  = (cur.st == CPM_ACTIVE);
	// R23 listen only in autobaud
	assign ack_enable = rx_enable && !cur.mode[`CPM_MODE_ABD];
	// R8 send right after sync
	assign tx_permit  = ack_enable;
	// R2 level interrupt while set
	assign irq = |(sr & cur.imr);
endmodule : cpm_core

// ===== hdl/cpm_defs.svh
// cpm_defs.svh - offsets, field positions, reset values and counts
// assumes: included by bare name from the cpm design and bench files
`ifndef CPM_DEFS_SVH
`define CPM_DEFS_SVH

// ==========================================================
// register byte offsets
`define CPM_MODE_OFS      8'h00
`define CPM_IER_OFS       8'h04
`define CPM_IDR_OFS       8'h08
`define CPM_IMR_OFS       8'h0C
`define CPM_SR_OFS        8'h10
`define CPM_BTR_OFS       8'h14
`define CPM_ECR_OFS       8'h18
`define CPM_TSTAMP_OFS    8'h1C
`define CPM_MB_MODE_OFS   8'h20
`define CPM_MB_STAT_OFS   8'h24
`define CPM_MB_LOW_OFS    8'h28
`define CPM_MB_HIGH_OFS   8'h2C
`define CPM_MB_CTRL_OFS   8'h30

// ==========================================================
// mode register fields
`define CPM_MODE_EN       0
`define CPM_MODE_LPM      1
`define CPM_MODE_ABD      2

// ==========================================================
// status / mask bit positions
`define CPM_SR_MB         0
`define CPM_SR_ERRA       16
`define CPM_SR_WARN       17
`define CPM_SR_ERRP       18
`define CPM_SR_BOFF       19
`define CPM_SR_SLEEP      20
`define CPM_SR_WAKE       21
`define CPM_SR_TOVF       22
`define CPM_SR_TSTP       23
`define CPM_IRQ_VALID     32'h00FF0001

// ==========================================================
// mailbox fields
`define CPM_MB_RDY        23
`define CPM_MB_LOST       24
`define CPM_MB_TCMD       23
`define CPM_MB_TYPE_LSB   24

// ==========================================================
// reset values and counts
`define CPM_BTR_RST       16'h0027
`define CPM_IDLE_BITS     4'hB
`define CPM_WARN_LIM      9'h060
`define CPM_PASS_LIM      9'h07F
`define CPM_BOFF_LIM      9'h0FF
`define CPM_TEC_STEP      9'h008
`define CPM_CNT_MAX       9'h1FF

`endif

// ===== hdl/cpm_idle_detect.sv
// cpm_idle_detect.sv - counts consecutive recessive bits
// assumes: can_rx synchronous to pclk, sampled on bit ticks
`include "cpm_defs.svh"
module cpm_idle_detect
	import cpm_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic enable,
	input  wire logic tick,
	input  wire logic can_rx,
	output logic      idle_seen
);
	typedef struct packed {
		logic [3:0] cnt;  // recessive run length
	} cpm_idle_type;

	cpm_idle_type cur;      // state
	cpm_idle_type next_cur; // next state

	// ==========================================================
	// any dominant bit restarts the run, so a frame in
	// progress defers sync to the next interframe space
	always_comb begin
		next_cur = cur;
		if (!enable) begin
			next_cur.cnt = 4'h0;
		end else if (tick && !can_rx) begin
			next_cur.cnt = 4'h0;
		end else if (tick && cur.cnt != `CPM_IDLE_BITS) begin
			next_cur.cnt = cur.cnt + 4'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign idle_seen = enable && (cur.cnt == `CPM_IDLE_BITS);
endmodule : cpm_idle_detect

// ===== hdl/cpm_pkg.sv
// cpm_pkg.sv - types shared by the cpm design files
// assumes: compiled before every cpm module
package cpm_pkg;

	// ==========================================================
	// controller state, gray along off-sync-active-sleep
	typedef enum logic [1:0] {
		CPM_OFF    = 2'h0,
		CPM_SYNC   = 2'h1,
		CPM_ACTIVE = 2'h3,
		CPM_SLEEP  = 2'h2
	} cpm_state_type;

	// ==========================================================
	// mailbox object type
	typedef enum logic [2:0] {
		CPM_MB_OFF  = 3'h0,
		CPM_MB_RX   = 3'h1,
		CPM_MB_RXOW = 3'h2
	} cpm_mbtype_type;

endpackage : cpm_pkg

// ===== tb/cpm_core_chk.sv
// cpm_core_chk.sv - port-level assertions for cpm_core
// assumes: bound to cpm_core, single pclk domain, async presetn
`include "cpm_defs.svh"
module cpm_core_chk
	import cpm_pkg::*;
(
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic       can_rx,
	input wire logic       tx_pending,
	input wire logic       rx_enable,
	input wire logic       ack_enable,
	input wire logic       tx_permit,
	input wire logic       irq
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// helper state
	logic       wr_mode;  // mode write at access edge
	logic       abd_on;   // autobaud as last written
	logic [4:0] rec_cnt;  // cycles since last dominant level
	logic       mode_seen; // enable ever written
	logic       ier_seen;  // interrupt enable ever written
	assign wr_mode = psel && penable && pwrite && paddr == `CPM_MODE_OFS;
	// counts saturate so a long idle bus never wraps to zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rec_cnt   <= 5'h00;
			mode_seen <= 1'b0;
			ier_seen  <= 1'b0;
			abd_on    <= 1'b0;
		end else begin
			if (wr_mode) abd_on <= pwdata[2];
			if (!can_rx) rec_cnt <= 5'h00;
			else if (rec_cnt != 5'h1F) rec_cnt <= rec_cnt + 5'h01;
			if (wr_mode && pwdata[0]) mode_seen <= 1'b1;
			if (psel && penable && pwrite && paddr == `CPM_IER_OFS)
				ier_seen <= 1'b1;
		end
	end
	default clocking dc @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================================
	// assertions
	tx_wait_a: assert property (
		tx_pending && rx_enable && !wr_mode |=> rx_enable)
		else $error("left active while transmit pending");
	sleep_stop_a: assert property (
		wr_mode && pwdata[1:0] == 2'b11 && !tx_pending && rx_enable
		|-> ##[1:3] !rx_enable) else $error("reception not stopped");
	sync_idle_a: assert property (
		$rose(rx_enable) |-> rec_cnt >= 5'h0B)
		else $error("synced without idle bus");
	send_idle_a: assert property (
		$rose(tx_permit) |-> rec_cnt >= 5'h0B)
		else $error("send permitted too early");
	reset_off_a: assert property (
		!mode_seen |-> !rx_enable) else $error("active while disabled");
	mask_reset_a: assert property (
		!ier_seen |-> !irq) else $error("irq while all masked");
	listen_only_a: assert property (
		abd_on |-> !ack_enable) else $error("ack while in autobaud");
	no_send_a: assert property (
		abd_on |-> !tx_permit) else $error("send while in autobaud");
endmodule : cpm_core_chk

bind cpm_core cpm_core_chk chk_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .can_rx(can_rx), .tx_pending(tx_pending),
	.rx_enable(rx_enable), .ack_enable(ack_enable),
	.tx_permit(tx_permit), .irq(irq));

// ===== tb/cpm_node.sv
// cpm_node.sv - frame engine and bus stand-in for cpm_core
// assumes: driven by tasks from the bench, all changes after pclk rise
module cpm_node (
	input wire logic pclk,
	output logic        can_rx,
	output logic        tx_pending,
	output logic        frame_sof,
	output logic        frame_eof,
	output logic        rx_frame_valid,
	output logic [31:0] rx_data_low,
	output logic [31:0] rx_data_high,
	output logic        rx_error,
	output logic        tx_error,
	output logic        rx_ok,
	output logic        tx_ok
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [6:0] ev; // one-cycle frame and counter events
	assign {frame_eof, frame_sof, rx_frame_valid} = ev[6:4];
	assign {tx_error, rx_error, tx_ok, rx_ok} = ev[3:0];
	initial begin
		{can_rx, tx_pending} = 2'h2;
		ev = 7'h00;
		{rx_data_low, rx_data_high} = 64'h0;
	end
	// frame start and end around each received word pair
	task frame(input logic [31:0] lo, input logic [31:0] hi);
		@(posedge pclk) ev <= 7'h20;
		@(posedge pclk) ev <= 7'h10;
		{rx_data_low, rx_data_high} <= {lo, hi};
		// released data shows garbage, not the last word
		@(posedge pclk) ev <= 7'h40;
		{rx_data_low, rx_data_high} <= {~lo, ~hi};
		@(posedge pclk) ev <= 7'h00;
	endtask : frame
	// traffic on the bus, ends recessive; five-cycle levels so
	// the per-bit sample cannot alias onto recessive only
	task busy(input int n);
		repeat (n) begin
			repeat (5) @(posedge pclk);
			can_rx <= ~can_rx;
		end
		@(posedge pclk) can_rx <= 1'b1;
	endtask : busy
	task evt(input logic [3:0] v);
		@(posedge pclk) ev <= {3'h0, v};
		@(posedge pclk) ev <= 7'h00;
	endtask : evt
	task pend(input logic b);
		@(posedge pclk) tx_pending <= b;
	endtask : pend
endmodule : cpm_node

// ===== tb/test_cpm_core.sv
// test_cpm_core.sv - self-checking bench for cpm_core over apb
// assumes: cpm_node drives the frame side, checker bound to the core
`include "cpm_defs.svh"
module test_cpm_core
	import cpm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, can_rx;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, lo, hi, v;
	logic tx_pending, sof, eof, rxv, rxe, txe, rxo, txo, rx_en, ack, txp;
	logic irq, last_err;
	int n_mismatch, n_checks;
	cpm_core uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .can_rx(can_rx), .tx_pending(tx_pending),
		.frame_sof(sof), .frame_eof(eof), .rx_frame_valid(rxv),
		.rx_data_low(lo), .rx_data_high(hi), .rx_error(rxe),
		.tx_error(txe), .rx_ok(rxo), .tx_ok(txo), .rx_enable(rx_en),
		.ack_enable(ack), .tx_permit(txp), .irq(irq));
	cpm_node node (.pclk(pclk), .can_rx(can_rx), .tx_pending(tx_pending),
		.frame_sof(sof), .frame_eof(eof), .rx_frame_valid(rxv),
		.rx_data_low(lo), .rx_data_high(hi), .rx_error(rxe),
		.tx_error(txe), .rx_ok(rxo), .tx_ok(txo));
	always #12.5 pclk = ~pclk;
	// ==========================================================
	// apb master and compare tasks
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk) penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		v = prdata;
		last_err = pslverr;
		{psel, penable} <= 2'b00;
	endtask : xfer
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk
	// read, mask, compare
	task rc(input string n, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(n, e, v & m);
	endtask : rc
	// bounded wait for the activity output
	task wrx(input logic e);
		for (int i = 0; i < 300 && rx_en !== e; i++) @(posedge pclk);
		chk("rx_enable", 32'(e), 32'(rx_en));
	endtask : wrx
	task results;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : results
	// watchdog, far beyond the expected run
	initial begin
		repeat (20000) @(posedge pclk);
		n_mismatch++;
		results();
	end
	// ==========================================================
	// main sequence
	initial begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata} = 0;
		{n_mismatch, n_checks} = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rc("imr", `CPM_IMR_OFS, 32'hFFFFFFFF, 32'h0);
		rc("sr", `CPM_SR_OFS, 32'h00300000, 32'h0);
		rc("btr", `CPM_BTR_OFS, 32'hFFFF, 32'h27);
		rc("gap", 8'h40, 32'hFFFFFFFF, 32'h0);
		chk("slverr", 32'h1, 32'(last_err));
		$display("test reset done");
		xfer(1'b1, `CPM_BTR_OFS, 32'h3);
		xfer(1'b1, `CPM_MODE_OFS, 32'h5);
		wrx(1'b1);
		chk("ack", 32'h0, 32'(ack));
		rc("sr", `CPM_SR_OFS, 32'h00300000, 32'h00200000);
		repeat (13) node.evt(4'h8);
		rc("ecr", `CPM_ECR_OFS, 32'hFFFFFFFF, 32'h0);
		xfer(1'b1, `CPM_MODE_OFS, 32'h1);
		// mode lands at the access edge; look once it has settled
		@(negedge pclk);
		chk("ack", 32'h1, 32'(ack));
		repeat (13) node.evt(4'h8);
		node.evt(4'h4);
		node.evt(4'h1);
		node.evt(4'h2);
		rc("ecr", `CPM_ECR_OFS, 32'hFFFFFFFF, 32'h00670000);
		rc("sr", `CPM_SR_OFS, 32'h000F0000, 32'h00030000);
		xfer(1'b1, `CPM_MODE_OFS, 32'h0);
		xfer(1'b1, `CPM_MODE_OFS, 32'h1);
		rc("ecr", `CPM_ECR_OFS, 32'hFFFFFFFF, 32'h0);
		wrx(1'b1);
		$display("test enable done");
		xfer(1'b1, `CPM_MB_MODE_OFS, 32'h01000000);
		node.frame(32'hA1, 32'hA2);
		node.frame(32'hB1, 32'hB2);
		rc("sr", `CPM_SR_OFS, 32'h00800001, 32'h00800001);
		rc("sr", `CPM_SR_OFS, 32'h00800000, 32'h0);
		rc("mbs", `CPM_MB_STAT_OFS, 32'h01800000, 32'h01800000);
		rc("mbl", `CPM_MB_LOW_OFS, 32'hFFFFFFFF, 32'hA1);
		rc("mbs", `CPM_MB_STAT_OFS, 32'h01800000, 32'h00800000);
		xfer(1'b1, `CPM_MB_CTRL_OFS, 32'h00800000);
		rc("mbs", `CPM_MB_STAT_OFS, 32'h00800000, 32'h0);
		xfer(1'b1, `CPM_MB_MODE_OFS, 32'h02000000);
		node.frame(32'hC1, 32'hC2);
		rc("mbs", `CPM_MB_STAT_OFS, 32'h01800000, 32'h00800000);
		node.frame(32'hD1, 32'hD2);
		rc("mbs", `CPM_MB_STAT_OFS, 32'h01800000, 32'h01800000);
		rc("mbl", `CPM_MB_LOW_OFS, 32'hFFFFFFFF, 32'hD1);
		rc("mbh", `CPM_MB_HIGH_OFS, 32'hFFFFFFFF, 32'hD2);
		rc("mbs", `CPM_MB_STAT_OFS, 32'h01000000, 32'h0);
		$display("test mailbox done");
		node.pend(1'b1);
		xfer(1'b1, `CPM_MODE_OFS, 32'h3);
		rc("sr", `CPM_SR_OFS, 32'h00100000, 32'h0);
		node.pend(1'b0);
		wrx(1'b0);
		rc("sr", `CPM_SR_OFS, 32'h00300000, 32'h00100000);
		xfer(1'b1, `CPM_IER_OFS, 32'h00100000);
		rc("imr", `CPM_IMR_OFS, 32'hFFFFFFFF, 32'h00100000);
		chk("irq", 32'h1, 32'(irq));
		xfer(1'b1, `CPM_IDR_OFS, 32'h00100000);
		rc("imr", `CPM_IMR_OFS, 32'hFFFFFFFF, 32'h0);
		chk("irq", 32'h0, 32'(irq));
		xfer(1'b1, `CPM_MB_MODE_OFS, 32'h01000000);
		node.frame(32'hE1, 32'hE2);
		rc("mbs", `CPM_MB_STAT_OFS, 32'h00800000, 32'h0);
		xfer(1'b1, `CPM_MODE_OFS, 32'h1);
		node.busy(16);
		chk("rx_enable", 32'h0, 32'(rx_en));
		wrx(1'b1);
		rc("sr", `CPM_SR_OFS, 32'h00300000, 32'h00200000);
		xfer(1'b1, `CPM_MODE_OFS, 32'h3);
		wrx(1'b0);
		$display("test sleep done");
		results();
	end
endmodule : test_cpm_core
